// File: include/pbmux_pkg.sv
package pbmux_pkg;
    // Register offsets (word addresses on the plain register port)
    localparam logic [3:0] REG_DATA = 4'h0;
    localparam logic [3:0] REG_DIR = 4'h1;
    localparam logic [3:0] REG_PULL = 4'h2;
    localparam logic [3:0] REG_DIER = 4'h3;
    localparam logic [3:0] REG_FUNC_LO = 4'h4;
    localparam logic [3:0] REG_FUNC_HI = 4'h5;
    localparam logic [3:0] REG_ADC_SEL = 4'h6;
    localparam logic [3:0] REG_INT_CFG = 4'h7;
    localparam logic [3:0] REG_PIN_IN = 4'h8;
    localparam logic [3:0] REG_IRQ_STAT = 4'h9;
    localparam logic [3:0] REG_IRQ_MASK = 4'hA;
    // Reset values
    localparam logic [3:0] RST_DIER = 4'hF;
    localparam logic [3:0] RST_ZERO4 = 4'h0;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    // Pin function selector codes, two bits per pin
    localparam logic [1:0] FN_PORT = 2'h0;
    localparam logic [1:0] FN_TIMER = 2'h1;
    localparam logic [1:0] FN_PWMG = 2'h2;
    // Edge select for the alternate interrupt line
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    // Pin positions within the four-bit group (bit 2 is index 0)
    localparam int IDX_BIT5 = 3;
    // Status bits
    localparam int ST_EXTINT = 0;
    localparam int ST_WAKE = 1;
endpackage

// File: verilog/pbmux_edge.sv
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection for the interrupt line
module pbmux_edge (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic din,
    input wire logic [1:0] mode,
    output logic edge_hit
);
    logic meta;
    logic sync;
    logic last;
    wire rise = sync & ~last;
    wire fall = ~sync & last;

    // Synchroniser and history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= din;
            sync <= meta;
            last <= sync;
        end
    end

    // Edge qualification by mode
    always_comb begin
        unique case (mode)
            pbmux_pkg::EDGE_RISE: edge_hit = rise;
            pbmux_pkg::EDGE_FALL: edge_hit = fall;
            default: edge_hit = rise | fall;
        endcase
    end
endmodule

// File: verilog/pbmux_top.sv
`timescale 1ns/1ps
// Operation
// RULE1: each pin digital input or push-pull output, pull-high per bit
// RULE2: writing zero to input-enable bit disables that pin's digital input
// RULE3: disabled digital input pin never causes power-down wake-up
// RULE4: bit five may feed interrupt 0 with rising, falling or both edges
// RULE5: pin n routes to ADC channel n for n from 2 to 5
// RULE6: bit five outputs Timer3 PWM; bits four, five output generator zero
// RULE7: bits two and four output Timer2 PWM
// RULE8: bits two and three output PWM generator two
// RULE9: enabled peripheral drives pin instead of latch; else latch, direction
module pbmux_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic [3:0] pin_pull_en,
    output logic [3:0] adc_chan_en,
    input wire logic timer2_pwm_out,
    input wire logic timer3_pwm_out,
    input wire logic pwm_generator0_out,
    input wire logic pwm_generator2_out,
    input wire logic power_down,
    output logic wake_req,
    output logic ext_irq_line0_alternate,
    output logic irq
);
    logic rst_s1;
    logic rst_n;
    logic [3:0] port_latch;
    logic [3:0] port_dir;
    logic [3:0] pull_en;
    logic [3:0] dier;
    logic [7:0] func_sel;
    logic [3:0] adc_sel;
    logic int_en;
    logic [1:0] int_edge;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] in_m;
    logic [3:0] in_s;
    logic [3:0] in_last;
    logic [3:0] next_pin_out;
    logic [3:0] next_oe_n;
    logic [3:0] periph_en;
    logic [3:0] periph_val;
    logic int_hit;
    logic [7:0] next_rdata;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Decode one write strobe per writable register
    function automatic logic wr_hit(input logic [3:0] a,
                                    input logic [3:0] off,
                                    input logic we);
        wr_hit = we && (a == off);
    endfunction

    wire w_data = wr_hit(reg_addr, pbmux_pkg::REG_DATA, reg_wr);
    wire w_dir = wr_hit(reg_addr, pbmux_pkg::REG_DIR, reg_wr);
    wire w_pull = wr_hit(reg_addr, pbmux_pkg::REG_PULL, reg_wr);
    wire w_dier = wr_hit(reg_addr, pbmux_pkg::REG_DIER, reg_wr);
    wire w_flo = wr_hit(reg_addr, pbmux_pkg::REG_FUNC_LO, reg_wr);
    wire w_fhi = wr_hit(reg_addr, pbmux_pkg::REG_FUNC_HI, reg_wr);
    wire w_adc = wr_hit(reg_addr, pbmux_pkg::REG_ADC_SEL, reg_wr);
    wire w_icfg = wr_hit(reg_addr, pbmux_pkg::REG_INT_CFG, reg_wr);
    wire w_stat = wr_hit(reg_addr, pbmux_pkg::REG_IRQ_STAT, reg_wr);
    wire w_mask = wr_hit(reg_addr, pbmux_pkg::REG_IRQ_MASK, reg_wr);

    // Configuration registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_latch <= pbmux_pkg::RST_ZERO4;
            port_dir <= pbmux_pkg::RST_ZERO4;
            pull_en <= pbmux_pkg::RST_ZERO4;
            dier <= pbmux_pkg::RST_DIER;
            func_sel <= pbmux_pkg::RST_ZERO8;
        end else begin
            if (w_data) port_latch <= reg_wdata[3:0];
            if (w_dir) port_dir <= reg_wdata[3:0]; // RULE1
            if (w_pull) pull_en <= reg_wdata[3:0]; // RULE1
            if (w_dier) dier <= reg_wdata[3:0]; // RULE2
            if (w_flo) func_sel[3:0] <= reg_wdata[3:0];
            if (w_fhi) func_sel[7:4] <= reg_wdata[3:0];
        end
    end

    // Analog and interrupt configuration
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adc_sel <= pbmux_pkg::RST_ZERO4;
            int_en <= 1'b0;
            int_edge <= pbmux_pkg::EDGE_BOTH;
            irq_mask <= 2'h0;
        end else begin
            if (w_adc) adc_sel <= reg_wdata[3:0]; // RULE5
            if (w_icfg) int_en <= reg_wdata[0]; // RULE4
            if (w_icfg) int_edge <= reg_wdata[2:1]; // RULE4
            if (w_mask) irq_mask <= reg_wdata[1:0];
        end
    end

    // Gated input sampling: disabled pins read zero
    wire [3:0] din_gated = pin_in & dier; // RULE2

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_m <= pbmux_pkg::RST_ZERO4;
            in_s <= pbmux_pkg::RST_ZERO4;
            in_last <= pbmux_pkg::RST_ZERO4;
        end else begin
            in_m <= din_gated;
            in_s <= in_m;
            in_last <= in_s;
        end
    end

    // Wake on toggle of enabled pins only
    wire toggle_any = |((in_s ^ in_last) & dier); // RULE3
    wire wake_ev = power_down & toggle_any; // RULE3

    // Alternate interrupt line on bit five
    wire int_src = din_gated[pbmux_pkg::IDX_BIT5] & int_en; // RULE4

    pbmux_edge u_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din(int_src),
        .mode(int_edge),
        .edge_hit(int_hit)
    );

    // Peripheral sources per pin, bit2..bit5
    wire [3:0] timer_src = {timer3_pwm_out, timer2_pwm_out, 1'b0,
                            timer2_pwm_out}; // RULE6 RULE7
    wire [3:0] pwmg_src = {pwm_generator0_out, pwm_generator0_out,
                           pwm_generator2_out, pwm_generator2_out}; // RULE6
    wire [3:0] timer_ok = 4'hD; // bit three has no timer output
    // Bits two and three carry generator two
    wire [3:0] pwmg_ok = 4'hF; // RULE8

    // Output selection per pin
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            wire [1:0] fs = func_sel[2*g+1:2*g];
            assign periph_en[g] =
                (fs == pbmux_pkg::FN_TIMER && timer_ok[g]) ||
                (fs == pbmux_pkg::FN_PWMG && pwmg_ok[g]);
            assign periph_val[g] = (fs == pbmux_pkg::FN_TIMER) ?
                timer_src[g] : pwmg_src[g];
            assign next_pin_out[g] = periph_en[g] ? periph_val[g]
                                                  : port_latch[g]; // RULE9
            assign next_oe_n[g] = ~(periph_en[g] | port_dir[g]); // RULE9
        end
    endgenerate

    // Read data mux
    always_comb begin
        next_rdata = pbmux_pkg::RST_ZERO8;
        unique case (reg_addr)
            pbmux_pkg::REG_DATA: next_rdata = {4'h0, port_latch};
            pbmux_pkg::REG_DIR: next_rdata = {4'h0, port_dir};
            pbmux_pkg::REG_PULL: next_rdata = {4'h0, pull_en};
            pbmux_pkg::REG_DIER: next_rdata = {4'h0, dier};
            pbmux_pkg::REG_FUNC_LO: next_rdata = {4'h0, func_sel[3:0]};
            pbmux_pkg::REG_FUNC_HI: next_rdata = {4'h0, func_sel[7:4]};
            pbmux_pkg::REG_ADC_SEL: next_rdata = {4'h0, adc_sel};
            pbmux_pkg::REG_INT_CFG: next_rdata = {5'h00, int_edge, int_en};
            pbmux_pkg::REG_PIN_IN: next_rdata = {4'h0, in_s};
            pbmux_pkg::REG_IRQ_STAT: next_rdata = {6'h00, irq_stat};
            pbmux_pkg::REG_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            default: next_rdata = pbmux_pkg::RST_ZERO8;
        endcase
    end

    // Sticky status, set wins over write-one clear
    wire [1:0] ev = {wake_ev, int_hit};
    wire [1:0] clr = w_stat ? reg_wdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~clr) | ev;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= pbmux_pkg::RST_ZERO8;
            pin_out <= pbmux_pkg::RST_ZERO4;
            pin_oe_n <= 4'hF;
            pin_pull_en <= pbmux_pkg::RST_ZERO4;
            adc_chan_en <= pbmux_pkg::RST_ZERO4;
            wake_req <= 1'b0;
            ext_irq_line0_alternate <= 1'b0;
            irq <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : pbmux_pkg::RST_ZERO8;
            pin_out <= next_pin_out;
            pin_oe_n <= next_oe_n;
            pin_pull_en <= pull_en & next_oe_n; // RULE1
            adc_chan_en <= adc_sel; // RULE5
            wake_req <= wake_ev; // RULE3
            ext_irq_line0_alternate <= int_hit; // RULE4
            irq <= |(((irq_stat & ~clr) | ev) & irq_mask);
        end
    end
endmodule

// File: verif/pbmux_top_asserts.sv
`timescale 1ns/1ps
// Port-level checks for the pin mux
module pbmux_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] pin_pull_en,
    input wire logic timer3_pwm_out,
    input wire logic pwm_generator0_out,
    input wire logic power_down,
    input wire logic wake_req,
    input wire logic ext_irq_line0_alternate
);
    logic [7:0] fhi;
    logic [3:0] dir;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Shadow copies of the upper function and direction registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fhi <= 8'h00;
            dir <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == pbmux_pkg::REG_FUNC_HI) fhi <= reg_wdata;
            if (reg_addr == pbmux_pkg::REG_DIR) dir <= reg_wdata[3:0];
        end
    end
    // Pad relations
    property p_pull; (pin_pull_en & ~pin_oe_n) == 4'h0; endproperty
    a_pull: assert property (p_pull) else $error("pull on driven pin");
    property p_t3; $past(fhi[3:2]) == pbmux_pkg::FN_TIMER |->
        !pin_oe_n[3] && pin_out[3] == $past(timer3_pwm_out); endproperty
    a_t3: assert property (p_t3) else $error("bit five timer");
    property p_g0; $past(fhi[1:0]) == pbmux_pkg::FN_PWMG |->
        !pin_oe_n[2] && pin_out[2] == $past(pwm_generator0_out); endproperty
    a_g0: assert property (p_g0) else $error("bit four pwm");
    property p_port; $past(fhi[3:2]) == pbmux_pkg::FN_PORT |->
        pin_oe_n[3] == !$past(dir[3]); endproperty
    a_port: assert property (p_port) else $error("bit five dir");
    // Wake and interrupt pulses
    property p_wpd; wake_req |-> power_down || $past(power_down); endproperty
    a_wpd: assert property (p_wpd) else $error("wake outside sleep");
    property p_wq; $stable(pin_in) [*6] |=> !wake_req; endproperty
    a_wq: assert property (p_wq) else $error("wake with no toggle");
    property p_ip; ext_irq_line0_alternate |=> !ext_irq_line0_alternate;
    endproperty
    a_ip: assert property (p_ip) else $error("irq pulse too long");
    property p_iq; $stable(pin_in[3]) [*6] |=> !ext_irq_line0_alternate;
    endproperty
    a_iq: assert property (p_iq) else $error("irq with no edge");
endmodule
bind pbmux_top pbmux_chk u_chk (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en, .timer3_pwm_out,
    .pwm_generator0_out, .power_down, .wake_req, .ext_irq_line0_alternate);

// File: verif/pbmux_board.sv
`timescale 1ns/1ps
// Board side: a weak source on each pad, overridden by the chip drive
module pbmux_board (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] src,
    output logic [3:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_n) | (src & pin_oe_n);
endmodule

// File: verif/test_pbmux_top.sv
`timescale 1ns/1ps
// Self-checking bench for the upper port B pin mux
module test_pbmux_top;
    typedef struct {logic [7:0] lo, hi; logic [3:0] dir, dat, pul, out, oe, pe;}
        pbmux_row_t;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] pin_in, pin_out, pin_oe_n, pin_pull_en, adc_chan_en;
    logic t2 = 1'b1, t3 = 1'b0, g0 = 1'b1, g2 = 1'b0, pdn = 1'b0;
    logic wake_req, ext_irq, irq, hit;
    logic [3:0] src = 4'h0;
    int error_cnt = 0;
    int checked = 0;
    pbmux_row_t rows [5] = '{'{8'h00, 8'h00, 4'hF, 4'h5, 4'hF, 4'h5, 4'h0, 4'h0},
        '{8'h00, 8'h00, 4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 4'hF},
        '{8'h01, 8'h05, 4'h0, 4'h0, 4'h0, 4'h5, 4'h2, 4'h0},
        '{8'h0A, 8'h0A, 4'h0, 4'h0, 4'h0, 4'hC, 4'h0, 4'h0},
        '{8'h04, 8'h00, 4'h0, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0}};
    pbmux_top dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en,
        .adc_chan_en, .timer2_pwm_out(t2), .timer3_pwm_out(t3),
        .pwm_generator0_out(g0), .pwm_generator2_out(g2), .power_down(pdn),
        .wake_req, .ext_irq_line0_alternate(ext_irq), .irq);
    pbmux_board board (.pin_out, .pin_oe_n, .src, .pin_in);
    // Clock and bus helpers
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp, string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask
    task automatic seen(input int w, output logic h);
        h = 1'b0;
        repeat (8) begin
            @(posedge clk_sys);
            #1 h = h | (w != 0 ? wake_req : ext_irq);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk("oe_rst", 8'h0F, {4'h0, pin_oe_n});
        chk("pull_rst", 8'h00, {4'h0, pin_pull_en});
        rd(pbmux_pkg::REG_DIER, 8'h0F, "dier_rst");
        rd(4'hF, 8'h00, "unmapped");
        $display("reset done");
        foreach (rows[i]) begin
            wr(pbmux_pkg::REG_FUNC_LO, rows[i].lo);
            wr(pbmux_pkg::REG_FUNC_HI, rows[i].hi);
            wr(pbmux_pkg::REG_DIR, {4'h0, rows[i].dir});
            wr(pbmux_pkg::REG_DATA, {4'h0, rows[i].dat});
            wr(pbmux_pkg::REG_PULL, {4'h0, rows[i].pul});
            repeat (2) @(posedge clk_sys);
            #1 chk("out", {4'h0, rows[i].out}, {4'h0, pin_out});
            chk("oe_n", {4'h0, rows[i].oe}, {4'h0, pin_oe_n});
            chk("pull", {4'h0, rows[i].pe}, {4'h0, pin_pull_en});
            $display("row %0d done", i);
        end
        wr(pbmux_pkg::REG_ADC_SEL, 8'h0A);
        repeat (2) @(posedge clk_sys);
        #1 chk("adc", 8'h0A, {4'h0, adc_chan_en});
        wr(pbmux_pkg::REG_ADC_SEL, 8'h00);
        // Edge modes both, rise, fall on bit five
        for (int m = 0; m < 3; m++) begin
            wr(pbmux_pkg::REG_INT_CFG, {5'h00, m[1:0], 1'b1});
            src[3] <= 1'b1;
            seen(0, hit);
            chk("irq_rise", {7'h00, m != 2}, {7'h00, hit});
            src[3] <= 1'b0;
            seen(0, hit);
            chk("irq_fall", {7'h00, m != 1}, {7'h00, hit});
        end
        rd(pbmux_pkg::REG_IRQ_STAT, 8'h01, "stat");
        wr(pbmux_pkg::REG_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 hit = irq;
        wr(pbmux_pkg::REG_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq_mask", 8'h01, {7'h00, hit ^ irq});
        wr(pbmux_pkg::REG_IRQ_STAT, 8'h01);
        rd(pbmux_pkg::REG_IRQ_STAT, 8'h00, "stat_clr");
        chk("irq_clr", 8'h00, {7'h00, irq});
        $display("interrupt done");
        @(posedge clk_sys);
        pdn <= 1'b1;
        src[0] <= 1'b1;
        seen(1, hit);
        chk("wake_on", 8'h01, {7'h00, hit});
        rd(pbmux_pkg::REG_PIN_IN, 8'h01, "pin_open");
        wr(pbmux_pkg::REG_DIER, 8'h0E);
        repeat (2) @(posedge clk_sys);
        rd(pbmux_pkg::REG_PIN_IN, 8'h00, "pin_gated");
        src[0] <= 1'b0;
        seen(1, hit);
        chk("wake_off", 8'h00, {7'h00, hit});
        $display("wake done");
        stop_test;
    end
    // Cut a hang short well past the expected run
    initial begin
        #500000;
        error_cnt++;
        stop_test;
    end
endmodule
